// File: rtl/channel_dividers.sv
// two cascaded-stage channel dividers with phase offset and duty fix
`timescale 1ns/1ps

// one divider stage: start level, coarse delay, high/low counting
module divider_stage
   import dividers_pkg::*;
(
   input wire logic aclk, // system clock
   input wire logic aresetn, // sync reset, active low
   input wire logic tick_in, // stage input clock enable
   input wire logic hold, // sync hold condition active (sync_n low)
   input wire logic [3:0] low_cnt, // low cycles minus one
   input wire logic [3:0] high_cnt, // high cycles minus one
   input wire logic [3:0] phase_offset, // coarse offset field
   input wire logic start_high, // start level and offset msb
   input wire logic bypass, // stage passes its input through
   input wire logic dcc_on, // duty correction enabled
   output logic level, // stage output level
   output logic tick_thru, // rising-edge enable for next stage
   output logic half_fix // falling edge moved half input cycle
);
   typedef enum logic [2:0]
   {
      ST_HOLD = 3'b001,
      ST_DELAY = 3'b010,
      ST_RUN = 3'b100
   } stage_state_t;

   stage_state_t state;
   logic [5:0] cnt;
   logic [5:0] delay;
   logic tick_out;
   logic odd_ratio;

   // coarse delay in stage input cycles
   always_comb
   begin
      if ({start_high, phase_offset} <= PHI_DIRECT_MAX)
         delay = {2'b00, phase_offset};
      else
         delay = {2'b00, phase_offset} + {2'b00, low_cnt} + 6'h01;
   end

   // ratio high+low+2 is odd when the two counts differ in parity
   assign odd_ratio = low_cnt[0] ^ high_cnt[0];
   assign tick_thru = bypass ? tick_in : tick_out;

   // hold, delay and run sequencing
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= ST_HOLD;
         cnt <= 6'h00;
         level <= 1'b0;
         tick_out <= 1'b0;
      end
      else
      begin
         tick_out <= 1'b0;
         case (state)
            ST_HOLD:
            begin
               level <= start_high;
               cnt <= delay;
               if (!hold)
                  state <= ST_DELAY;
            end
            ST_DELAY:
            begin
               if (hold)
                  state <= ST_HOLD;
               else if (tick_in && cnt == 6'h00)
               begin
                  state <= ST_RUN;
                  cnt <= {2'b00, level ? high_cnt : low_cnt};
               end
               else if (tick_in)
                  cnt <= cnt - 6'h01;
            end
            ST_RUN:
            begin
               if (hold)
                  state <= ST_HOLD;
               else if (tick_in && cnt == 6'h00)
               begin
                  level <= !level;
                  tick_out <= !level;
                  cnt <= {2'b00, level ? low_cnt : high_cnt};
               end
               else if (tick_in)
                  cnt <= cnt - 6'h01;
            end
            default:
               state <= ST_HOLD;
         endcase
      end
   end

   // half-cycle falling edge shift for odd ratios under correction
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         half_fix <= 1'b0;
      else
         half_fix <= dcc_on && odd_ratio && !bypass &&
                     state == ST_RUN;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_released;
      state == ST_HOLD && !hold;
   endsequence
   sequence s_delay_loaded;
      state == ST_DELAY && cnt == $past(delay);
   endsequence

   property p_hold_level;
      state == ST_HOLD && hold |=> level == $past(start_high);
   endproperty
   a_hold_level: assert property (p_hold_level)
      else $error("start level not applied while held");

   property p_delay_load;
      s_released |=> s_delay_loaded;
   endproperty
   a_delay_load: assert property (p_delay_load)
      else $error("coarse delay not loaded at release");

   property p_high_load;
      state == ST_RUN && !hold && tick_in && cnt == 6'h00 && !level
      |=> level && tick_out && cnt == {2'b00, $past(high_cnt)};
   endproperty
   a_high_load: assert property (p_high_load)
      else $error("high phase length wrong");

   property p_low_load;
      state == ST_RUN && !hold && tick_in && cnt == 6'h00 && level
      |=> !level && !tick_out && cnt == {2'b00, $past(low_cnt)};
   endproperty
   a_low_load: assert property (p_low_load)
      else $error("low phase length wrong");

   property p_half_odd;
      state == ST_RUN && dcc_on && odd_ratio && !bypass |=> half_fix;
   endproperty
   a_half_odd: assert property (p_half_odd)
      else $error("odd stage lost duty correction");

   property p_half_even;
      !odd_ratio || !dcc_on || bypass |=> !half_fix;
   endproperty
   a_half_even: assert property (p_half_even)
      else $error("duty shift on even, bypassed or disabled stage");
endmodule : divider_stage

module channel_dividers
   import dividers_pkg::*;
(
   input wire logic aclk, // system clock, 250 MHz
   input wire logic aresetn, // sync reset, active low
   input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic div_tick, // channel input clock enable
   input wire logic sync_n, // sync hold, active low
   output logic [1:0] ch_out, // channel output levels
   output logic [1:0] ch_half // channel falling edge half shift
);
   logic [7:0] cyc1 [2];
   logic [7:0] phase [2];
   logic [7:0] cyc2 [2];
   logic [7:0] start [2];
   logic [7:0] dcc [2];
   logic aw_got, w_got, next_aw_got, next_w_got;
   logic [ADDR_W-1:0] waddr;
   logic [7:0] wdata_q;
   logic wstrb_q;
   logic wr_hit, rd_hit, do_write;
   logic [7:0] rd_val;
   logic [1:0] lvl1, lvl2, tk1, tk2, half1, half2;

   assign do_write = aw_got && w_got && !s_axi_bvalid;

   // write channel capture, both orders
   always_comb
   begin
      next_aw_got = aw_got || (s_axi_awvalid && s_axi_awready);
      next_w_got = w_got || (s_axi_wvalid && s_axi_wready);
      if (s_axi_bvalid && s_axi_bready)
      begin
         next_aw_got = 1'b0;
         next_w_got = 1'b0;
      end
   end

   // write handshake and response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         waddr <= '0;
         wdata_q <= 8'h00;
         wstrb_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         s_axi_awready <= !next_aw_got;
         s_axi_wready <= !next_w_got;
         if (s_axi_awvalid && s_axi_awready)
            waddr <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_q <= s_axi_wdata[7:0];
            wstrb_q <= s_axi_wstrb[0];
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         else if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // write decode
   always_comb
   begin
      wr_hit = waddr[WORD_LSB-1:0] == 2'b00 &&
               waddr[ADDR_W-1:WORD_LSB] == IDX_STATUS;
      for (int c = 0; c < 2; c++)
         if (waddr[ADDR_W-1:WORD_LSB] == IDX_CYC1[c] ||
             waddr[ADDR_W-1:WORD_LSB] == IDX_PHASE[c] ||
             waddr[ADDR_W-1:WORD_LSB] == IDX_CYC2[c] ||
             waddr[ADDR_W-1:WORD_LSB] == IDX_START[c] ||
             waddr[ADDR_W-1:WORD_LSB] == IDX_DCC[c])
            wr_hit = waddr[WORD_LSB-1:0] == 2'b00;
   end

   // configuration registers, low byte lane only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         for (int c = 0; c < 2; c++)
         begin
            cyc1[c] <= RST_CYC;
            phase[c] <= RST_PHASE;
            cyc2[c] <= RST_CYC;
            start[c] <= RST_START;
            dcc[c] <= RST_DCC;
         end
      else if (do_write && wstrb_q && waddr[WORD_LSB-1:0] == 2'b00)
         for (int c = 0; c < 2; c++)
         begin
            if (waddr[ADDR_W-1:WORD_LSB] == IDX_CYC1[c])
               cyc1[c] <= wdata_q;
            if (waddr[ADDR_W-1:WORD_LSB] == IDX_PHASE[c])
               phase[c] <= wdata_q;
            if (waddr[ADDR_W-1:WORD_LSB] == IDX_CYC2[c])
               cyc2[c] <= wdata_q;
            if (waddr[ADDR_W-1:WORD_LSB] == IDX_START[c])
               start[c] <= wdata_q;
            if (waddr[ADDR_W-1:WORD_LSB] == IDX_DCC[c])
               dcc[c] <= wdata_q;
         end
   end

   // read decode
   always_comb
   begin
      rd_hit = s_axi_araddr[WORD_LSB-1:0] == 2'b00 &&
               s_axi_araddr[ADDR_W-1:WORD_LSB] == IDX_STATUS;
      rd_val = {2'b00, ch_half, tk2 | tk1, ch_out};
      for (int c = 0; c < 2; c++)
      begin
         if (s_axi_araddr[ADDR_W-1:WORD_LSB] == IDX_CYC1[c])
            rd_val = cyc1[c];
         if (s_axi_araddr[ADDR_W-1:WORD_LSB] == IDX_PHASE[c])
            rd_val = phase[c];
         if (s_axi_araddr[ADDR_W-1:WORD_LSB] == IDX_CYC2[c])
            rd_val = cyc2[c];
         if (s_axi_araddr[ADDR_W-1:WORD_LSB] == IDX_START[c])
            rd_val = start[c];
         if (s_axi_araddr[ADDR_W-1:WORD_LSB] == IDX_DCC[c])
            rd_val = dcc[c];
         if (s_axi_araddr[ADDR_W-1:WORD_LSB] == IDX_CYC1[c] ||
             s_axi_araddr[ADDR_W-1:WORD_LSB] == IDX_PHASE[c] ||
             s_axi_araddr[ADDR_W-1:WORD_LSB] == IDX_CYC2[c] ||
             s_axi_araddr[ADDR_W-1:WORD_LSB] == IDX_START[c] ||
             s_axi_araddr[ADDR_W-1:WORD_LSB] == IDX_DCC[c])
            rd_hit = s_axi_araddr[WORD_LSB-1:0] == 2'b00;
      end
   end

   // read handshake, answer one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_hit ? {24'h00_0000, rd_val} : 32'h0000_0000;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
      else
         s_axi_arready <= !s_axi_rvalid;
   end

   // two stages per channel, second stage clocked by the first
   for (genvar c = 0; c < 2; c++)
   begin : g_ch
      divider_stage u_s1 (
         .aclk(aclk),
         .aresetn(aresetn),
         .tick_in(div_tick),
         .hold(!sync_n),
         .low_cnt(cyc1[c][NIB_HI+:4]),
         .high_cnt(cyc1[c][NIB_LO+:4]),
         .phase_offset(phase[c][NIB_LO+:4]),
         .start_high(start[c][SH1_BIT]),
         .bypass(start[c][BYP1_BIT]),
         .dcc_on(!dcc[c][DCC_OFF_BIT]),
         .level(lvl1[c]),
         .tick_thru(tk1[c]),
         .half_fix(half1[c])
      );
      divider_stage u_s2 (
         .aclk(aclk),
         .aresetn(aresetn),
         .tick_in(tk1[c]),
         .hold(!sync_n),
         .low_cnt(cyc2[c][NIB_HI+:4]),
         .high_cnt(cyc2[c][NIB_LO+:4]),
         .phase_offset(phase[c][NIB_HI+:4]),
         .start_high(start[c][SH2_BIT]),
         .bypass(start[c][BYP2_BIT]),
         .dcc_on(!dcc[c][DCC_OFF_BIT]),
         .level(lvl2[c]),
         .tick_thru(tk2[c]),
         .half_fix(half2[c])
      );
   end

   // channel output: last active stage, or input when both bypassed
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ch_out <= 2'b00;
         ch_half <= 2'b00;
      end
      else
         for (int c = 0; c < 2; c++)
         begin
            if (!start[c][BYP2_BIT])
               ch_out[c] <= lvl2[c];
            else if (!start[c][BYP1_BIT])
               ch_out[c] <= lvl1[c];
            else
               ch_out[c] <= div_tick;
            ch_half[c] <= start[c][BYP2_BIT] ? half1[c] : half2[c];
         end
   end

   // store and response land together, one edge after both channels taken
   property p_phase_write;
      @(posedge aclk) disable iff (!aresetn)
      do_write && wstrb_q && waddr == {IDX_PHASE[0], 2'b00}
      |=> phase[0] == $past(wdata_q) && s_axi_bvalid;
   endproperty
   a_phase_write: assert property (p_phase_write)
      else $error("phase offset write lost");

   property p_start_write;
      @(posedge aclk) disable iff (!aresetn)
      do_write && wstrb_q && waddr == {IDX_START[1], 2'b00}
      |=> start[1] == $past(wdata_q);
   endproperty
   a_start_write: assert property (p_start_write)
      else $error("start level write lost");
endmodule : channel_dividers

// File: rtl/dividers_pkg.sv
// constants for the cascaded channel divider phase and duty block
package dividers_pkg;
   // register indices; byte address is four times the index
   localparam logic [11:0] IDX_CYC1 [2] = '{12'h199, 12'h19e};
   localparam logic [11:0] IDX_PHASE [2] = '{12'h19a, 12'h19f};
   localparam logic [11:0] IDX_CYC2 [2] = '{12'h19b, 12'h1a0};
   localparam logic [11:0] IDX_START [2] = '{12'h19c, 12'h1a1};
   localparam logic [11:0] IDX_DCC [2] = '{12'h19d, 12'h1a2};
   localparam logic [11:0] IDX_STATUS = 12'h1a3;
   localparam int ADDR_W = 14;
   localparam int WORD_LSB = 2;
   // field positions
   localparam int NIB_LO = 0;  // high-cycle count, stage 1 phase offset
   localparam int NIB_HI = 4;  // low-cycle count, stage 2 phase offset
   localparam int SH1_BIT = 0;
   localparam int SH2_BIT = 1;
   localparam int BYP1_BIT = 4;
   localparam int BYP2_BIT = 5;
   localparam int DCC_OFF_BIT = 0;
   // reset values
   localparam logic [7:0] RST_CYC = 8'h00;
   localparam logic [7:0] RST_PHASE = 8'h00;
   localparam logic [7:0] RST_START = 8'h00;
   localparam logic [7:0] RST_DCC = 8'h00;
   // delay: values above this wrap and add the low count plus one
   localparam logic [4:0] PHI_DIRECT_MAX = 5'h0f;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dividers_pkg

// File: sim/tb_top.sv
// self-checking bench for the channel divider phase and duty block
`timescale 1ns/1ps
module tb_top
   import dividers_pkg::*;
;
   logic aclk, aresetn, sync_n, div_tick;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
   logic [3:0] s_axi_wstrb, tick_period;
   logic [1:0] s_axi_bresp, s_axi_rresp, ch_out, ch_half, resp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [1:0] tr [0:255];
   logic [1:0] hf [0:255];
   int n_mismatch, num_checks, cyc;

   // 250 MHz system clock
   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   channel_dividers channel_dividers_inst (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .div_tick(div_tick), .sync_n(sync_n),
      .ch_out(ch_out), .ch_half(ch_half));

   tick_source tick_source_inst (.aclk(aclk), .aresetn(aresetn),
      .period(tick_period), .div_tick(div_tick));

   // verdict and end of run
   task automatic summarize();
   begin
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
   endtask : summarize

   // cycle watchdog against a hung handshake
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         summarize();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
   begin
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask : check

   // write one register word, hold each channel until taken
   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
   begin
      @(posedge aclk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      resp = s_axi_bresp;
   end
   endtask : wr

   // read one register word
   task automatic rd_reg(input logic [11:0] idx);
   begin
      @(posedge aclk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      resp = s_axi_rresp;
      rdv = s_axi_rdata;
   end
   endtask : rd_reg

   // one channel: counts of both stages, offsets, start, correction
   task automatic cfg(input int c, input logic [7:0] c1, c2, ph, st, dc);
   begin
      wr(IDX_CYC1[c], c1);
      wr(IDX_CYC2[c], c2);
      wr(IDX_PHASE[c], ph);
      wr(IDX_START[c], st);
      wr(IDX_DCC[c], dc);
   end
   endtask : cfg

   // hold, optionally check static level, release and capture
   task automatic resync(input logic [1:0] hold_exp, input bit chk);
   begin
      @(posedge aclk);
      sync_n <= 1'b0;
      repeat (6) @(posedge aclk);
      if (chk) check(ch_out, hold_exp);
      sync_n <= 1'b1;
      for (int i = 0; i < 256; i++)
      begin
         @(posedge aclk);
         tr[i] = ch_out;
         hf[i] = ch_half;
      end
   end
   endtask : resync

   function automatic int rise(input int ch, input int k);
      int n;
   begin
      n = 0;
      for (int i = 1; i < 256; i++)
         if (tr[i][ch] === 1'b1 && tr[i-1][ch] === 1'b0)
         begin
            n++;
            if (n == k) return i;
         end
      return -1;
   end
   endfunction : rise

   function automatic int high_len(input int ch, input int k);
      int i, n;
   begin
      i = rise(ch, k);
      n = 0;
      while (i >= 0 && i < 256 && tr[i][ch] === 1'b1)
      begin
         n++;
         i++;
      end
      return n;
   end
   endfunction : high_len

   // reset values, read back, unmapped word
   task automatic t_regs();
      logic [11:0] ix [8];
   begin
      ix = '{IDX_CYC1[0], IDX_PHASE[0], IDX_CYC2[0], IDX_START[0],
         IDX_CYC1[1], IDX_PHASE[1], IDX_CYC2[1], IDX_START[1]};
      foreach (ix[i])
      begin
         rd_reg(ix[i]);
         check(rdv, 32'h0);
         wr(ix[i], 8'h5a ^ 8'(i));
      end
      foreach (ix[i])
      begin
         rd_reg(ix[i]);
         check(rdv, {24'h0, 8'h5a ^ 8'(i)});
      end
      // low strobe clear: answered OKAY, nothing stored
      s_axi_wstrb <= 4'h0;
      wr(IDX_PHASE[0], 8'hff);
      check(resp, RESP_OKAY);
      s_axi_wstrb <= 4'h1;
      rd_reg(IDX_PHASE[0]);
      check(resp, RESP_OKAY);
      check(rdv, 32'h5b);
      wr(12'h198, 8'hff);
      check(resp, RESP_SLVERR);
      rd_reg(12'h198);
      check(resp, RESP_SLVERR);
      check(rdv, 32'h0);
   end
   endtask : t_regs

   // odd and even first stage: counts and duty fix flag
   task automatic t_duty();
   begin
      tick_period <= 4'h1;
      cfg(0, 8'h21, 8'h00, 8'h00, 8'h20, 8'h00);
      cfg(1, 8'h11, 8'h00, 8'h00, 8'h20, 8'h00);
      resync(2'b00, 1'b1);
      check(rise(0, 2) - rise(0, 1), 5);
      check(high_len(0, 1), 2);
      check(rise(1, 2) - rise(1, 1), 4);
      check(high_len(1, 2), 2);
      check(hf[255], 2'b01);
      wr(IDX_DCC[0], 8'h01);
      resync(2'b00, 1'b1);
      check(hf[255], 2'b00);
   end
   endtask : t_duty

   // coarse offsets of first and second stage
   task automatic t_delay();
   begin
      cfg(0, 8'h11, 8'h00, 8'h00, 8'h20, 8'h00);
      cfg(1, 8'h11, 8'h00, 8'h05, 8'h20, 8'h00);
      resync(2'b00, 1'b1);
      check(rise(1, 1) - rise(0, 1), 5);
      wr(IDX_PHASE[1], 8'h0f);
      resync(2'b00, 1'b1);
      check(rise(1, 1) - rise(0, 1), 15);
      wr(IDX_START[0], 8'h21);
      wr(IDX_START[1], 8'h21);
      wr(IDX_PHASE[1], 8'h03);
      resync(2'b11, 1'b1);
      check(rise(1, 1) - rise(0, 1), 3);
      tick_period <= 4'h3;
      cfg(0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      cfg(1, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00);
      resync(2'b00, 1'b1);
      check(rise(0, 2) - rise(0, 1), 12);
      check(rise(1, 1) - rise(0, 1), 6);
      check(hf[255], 2'b00);
   end
   endtask : t_delay

   // both stages bypassed: input clock passes straight through
   task automatic t_bypass();
   begin
      tick_period <= 4'h2;
      wr(IDX_START[0], 8'h30);
      resync(2'b00, 1'b0);
      check(rise(0, 2) - rise(0, 1), 2);
      check(high_len(0, 2), 1);
      check(hf[255], 2'b00);
   end
   endtask : t_bypass

   // reset, then the scenarios in turn
   initial
   begin
      aresetn = 1'b0;
      sync_n = 1'b1;
      tick_period = 4'h1;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h1;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      n_mismatch = 0;
      num_checks = 0;
      cyc = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_regs();
      t_duty();
      t_delay();
      t_bypass();
      summarize();
   end
endmodule : tb_top

// File: sim/tick_source.sv
// channel input clock model: one enable pulse every period cycles
`timescale 1ns/1ps
module tick_source
(
   input wire logic aclk, // system clock
   input wire logic aresetn, // sync reset, active low
   input wire logic [3:0] period, // cycles per input clock, 1 or more
   output logic div_tick // one-cycle input clock enable
);
   logic [3:0] cnt;
   // free-running input clock; a stale count wraps at once
   always_ff @(posedge aclk)
   begin
      if (!aresetn || cnt >= period - 4'h1)
         cnt <= 4'h0;
      else
         cnt <= cnt + 4'h1;
   end
   // pulse on count zero, silent in reset
   assign div_tick = aresetn && (cnt == 4'h0);
endmodule : tick_source
